// [design/delay_timer.v]
// Loadable down-counter that pulses when its count expires.
`timescale 1ns/100ps
`default_nettype none
module delay_timer
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire        load,
    input  wire [7:0]  count,
    output wire        busy,
    output reg         done
);
    reg [7:0] remain;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            remain <= 8'h00;
            done   <= 1'b0;
        end
        else if (load)
        begin
            remain <= count;
            done   <= 1'b0;
        end
        else
        begin
            done <= (remain == 8'h01);
            if (remain != 8'h00)
                remain <= remain - 8'h01;
        end
    end

    assign busy = (remain != 8'h00);
endmodule // delay_timer
`default_nettype wire

// [design/dram_training_timing.v]
// Device-side training logic: command-bus readback, write-level feedback, termination, vref mode.
`timescale 1ns/100ps
`default_nettype none
`include "dram_training_timing_defs.vh"
module dram_training_timing
(
    input  wire       CLK_SYS,
    input  wire       RST_N,
    input  wire       CK,
    input  wire       CKE,
    input  wire       CS,
    input  wire [5:0] CA,
    input  wire       DQS,
    input  wire       CBT_MODE,
    input  wire       WL_MODE,
    input  wire       VREF_HC_REQ,
    output reg  [7:0] DQ_OUT,
    output reg        DQ_OE_N,
    output reg        TERM_ON,
    output reg        VREF_HC_ACTIVE,
    output wire       VREF_HC_BUSY
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    reg [4:0] meta;
    reg [4:0] sync;
    reg [4:0] prev;
    reg [5:0] ca_meta;
    reg [5:0] ca_sync;

    always @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            // Clock enable idles high, so its stages reset high and no false edge follows.
            meta    <= 5'h02;
            sync    <= 5'h02;
            prev    <= 5'h02;
            ca_meta <= 6'h00;
            ca_sync <= 6'h00;
        end
        else
        begin
            meta    <= {VREF_HC_REQ, DQS, CS, CKE, CK};
            sync    <= meta;
            prev    <= sync;
            ca_meta <= CA;
            ca_sync <= ca_meta;
        end
    end

    wire ck_s       = sync[0];
    wire cke_s      = sync[1];
    wire cs_rise    = sync[2] & ~prev[2];
    wire dqs_rise   = sync[3] & ~prev[3];
    wire cke_change = sync[1] ^ prev[1];
    wire vref_req   = sync[4];

    // ****************************************************************
    // Counter loads cut to the counter width
    // ****************************************************************
    // Three cycles pass between a pin edge and the logic that acts on it.
    localparam [31:0] readback_load = `ASYNC_READBACK_CYC;
    localparam [31:0] wl_done_load  = `WL_FEEDBACK_CYC - `SYNC_LATENCY_CYC;
    localparam [31:0] term_on_load  = `TERM_ON_CYC - 1;
    localparam [31:0] term_off_load = `TERM_OFF_CYC - 1;
    localparam [31:0] vref_on_load  = `VREF_HC_ENABLE_CYC - `SYNC_LATENCY_CYC;
    localparam [31:0] vref_off_load = `VREF_HC_DISABLE_CYC - `SYNC_LATENCY_CYC;

    wire [7:0] readback_count = readback_load[7:0];
    wire [7:0] wl_done_count  = wl_done_load[7:0];
    wire [7:0] term_on_count  = term_on_load[7:0];
    wire [7:0] term_off_count = term_off_load[7:0];
    wire [7:0] vref_on_count  = vref_on_load[7:0];
    wire [7:0] vref_off_count = vref_off_load[7:0];

    // ****************************************************************
    // Command-bus training readback
    // ****************************************************************
    reg  [5:0] cbt_sample;
    wire       cbt_busy;
    wire       cbt_done;

    // A new sample restarts the timer, so only the last one is reported.
    wire cbt_take = CBT_MODE & ~cke_s & cs_rise;

    always @(posedge CLK_SYS)
    begin
        if (!RST_N)
            cbt_sample <= 6'h00;
        else if (cbt_take)
            cbt_sample <= ca_sync;
    end

    delay_timer u_cbt_timer
    (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .load  (cbt_take),
        .count (readback_count),
        .busy  (cbt_busy),
        .done  (cbt_done)
    );

    // ****************************************************************
    // Write-leveling feedback
    // ****************************************************************
    reg       wl_level;
    reg [7:0] wl_cnt;
    reg       wl_pend;

    always @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            wl_level <= 1'b0;
            wl_cnt   <= 8'h00;
            wl_pend  <= 1'b0;
        end
        else if (WL_MODE && dqs_rise)
        begin
            wl_level <= ck_s;
            wl_cnt   <= 8'h01;
            wl_pend  <= 1'b1;
        end
        else if (wl_pend)
        begin
            wl_cnt  <= wl_cnt + 8'h01;
            wl_pend <= (wl_cnt < wl_done_count);
        end
    end

    // The synchroniser uses most of the feedback window, so the answer follows one cycle later.
    wire wl_ready = wl_pend & (wl_cnt >= wl_done_count);

    always @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            DQ_OUT  <= 8'h00;
            DQ_OE_N <= 1'b1;
        end
        else if (cbt_done)
        begin
            DQ_OUT  <= {2'h0, cbt_sample};
            DQ_OE_N <= 1'b0;
        end
        else if (WL_MODE && wl_ready)
        begin
            DQ_OUT  <= {8{wl_level}};
            DQ_OE_N <= 1'b0;
        end
        else if (!CBT_MODE && !WL_MODE)
            DQ_OE_N <= 1'b1;
    end

    // ****************************************************************
    // Termination latency from clock-enable edges
    // ****************************************************************
    reg [7:0] term_cnt;
    reg       term_target;

    always @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            term_cnt    <= 8'h00;
            term_target <= 1'b0;
            TERM_ON     <= 1'b0;
        end
        else if (CBT_MODE && cke_change)
        begin
            term_target <= ~cke_s;
            term_cnt    <= cke_s ? term_off_count : term_on_count;
        end
        else if (term_cnt != 8'h00)
            term_cnt <= term_cnt - 8'h01;
        else
            TERM_ON <= term_target;
    end

    // ****************************************************************
    // Vref high-current mode switching
    // ****************************************************************
    reg [7:0] vref_cnt;

    always @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            vref_cnt       <= 8'h00;
            VREF_HC_ACTIVE <= 1'b0;
        end
        else if (vref_req != VREF_HC_ACTIVE)
        begin
            if (vref_cnt == (vref_req ? vref_on_count : vref_off_count))
            begin
                VREF_HC_ACTIVE <= vref_req;
                vref_cnt       <= 8'h00;
            end
            else
                vref_cnt <= vref_cnt + 8'h01;
        end
        else
            vref_cnt <= 8'h00;
    end

    assign VREF_HC_BUSY = (vref_req != VREF_HC_ACTIVE) | cbt_busy;
endmodule // dram_training_timing
`default_nettype wire

// [shared/dram_training_timing_defs.vh]
// Timing constants for the training-mode model of the DRAM device.
`ifndef DRAM_TRAINING_TIMING_DEFS_VH
`define DRAM_TRAINING_TIMING_DEFS_VH
`define SYS_CLK_PS              5000
`define ASYNC_READBACK_DELAY_PS 20000
`define ASYNC_READBACK_CYC      (`ASYNC_READBACK_DELAY_PS / `SYS_CLK_PS)
`define WL_FEEDBACK_DELAY_PS    20000
`define WL_FEEDBACK_CYC         (`WL_FEEDBACK_DELAY_PS / `SYS_CLK_PS)
`define TERM_ON_LATENCY_PS      20000
`define TERM_ON_CYC             ((`TERM_ON_LATENCY_PS + `SYS_CLK_PS - 1) / `SYS_CLK_PS)
`define TERM_OFF_LATENCY_PS     20000
`define TERM_OFF_CYC            ((`TERM_OFF_LATENCY_PS + `SYS_CLK_PS - 1) / `SYS_CLK_PS)
`define VREF_HC_ENABLE_PS       200000
`define VREF_HC_ENABLE_CYC      (`VREF_HC_ENABLE_PS / `SYS_CLK_PS)
`define VREF_HC_DISABLE_PS      100000
`define VREF_HC_DISABLE_CYC     (`VREF_HC_DISABLE_PS / `SYS_CLK_PS)
`define SYNC_LATENCY_CYC        3
`define CNT_W                   8
`define DQ_W                    8
`endif

// [sim/dram_ctl_model.sv]
// Memory controller model driving clock, commands and strobe.
`timescale 1ns/100ps
`default_nettype none
module dram_ctl_model
(
    input  wire logic       clk,
    output var  logic       ck,
    output var  logic       cke,
    output var  logic       cs,
    output var  logic [5:0] ca,
    output var  logic       dqs,
    output var  logic       cbt,
    output var  logic       wl
);
    logic run = 1'b0;
    initial {ck, cke, cs, ca, dqs, cbt, wl} = 12'h400;
    always #24 if (run) ck = ~ck;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cbt_enter;
        run = 1'b1;
        tick(30);
        dqs <= 1'b0;
        cbt <= 1'b1;
        tick(2);
        cke <= 1'b0;
        tick(50);
    endtask
    task automatic cbt_cmd(input logic [5:0] v, input int gap);
        ca <= v;
        tick(1);
        cs <= 1'b1;
        tick(1);
        cs <= 1'b0;
        tick(gap);
    endtask
    task automatic cbt_exit;
        tick(2);
        cke <= 1'b1;
        tick(50);
        cbt <= 1'b0;
        run = 1'b0;
    endtask
    task automatic wl_edge(input logic lvl);
        run = 1'b1;
        wl <= 1'b1;
        tick(400);
        if (lvl) @(posedge ck); else @(negedge ck);
        tick(2);
        dqs <= 1'b1;
        tick(40);
        dqs <= 1'b0;
        tick(40);
        wl <= 1'b0;
        run = 1'b0;
        tick(1);
    endtask
endmodule // dram_ctl_model
`default_nettype wire

// [sim/dram_training_timing_asserts.sv]
// Checker for the device side of the training logic.
`timescale 1ns/100ps
`default_nettype none
module dram_training_timing_asserts
(
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       CK,
    input wire logic       CKE,
    input wire logic       CS,
    input wire logic [5:0] CA,
    input wire logic       DQS,
    input wire logic       CBT_MODE,
    input wire logic       WL_MODE,
    input wire logic       VREF_HC_REQ,
    input wire logic [7:0] DQ_OUT,
    input wire logic       DQ_OE_N,
    input wire logic       TERM_ON,
    input wire logic       VREF_HC_ACTIVE
);
    logic [5:0] ca_seen;
    logic       ck_seen;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    always_ff @(posedge CLK_SYS)
    begin
        if ($rose(CS)) ca_seen <= CA;
        if ($rose(DQS)) ck_seen <= CK;
    end
    cbt_readback_a: assert property ($rose(CS) && CBT_MODE && !CKE |->
        ##[3:10] !DQ_OE_N && DQ_OUT == {2'h0, ca_seen}) else $error("readback missing");
    cbt_last_only_a: assert property ($changed(DQ_OUT) && CBT_MODE |->
        DQ_OUT[5:0] == ca_seen) else $error("stale sample shown");
    term_on_a: assert property ($fell(CKE) && CBT_MODE |=> !TERM_ON [*3] ##[1:6] TERM_ON)
        else $error("termination on early or late");
    term_off_a: assert property ($rose(CKE) && CBT_MODE |=> TERM_ON [*3] ##[1:6] !TERM_ON)
        else $error("termination off early or late");
    vref_on_a: assert property ($rose(VREF_HC_REQ) |-> ##[1:40] VREF_HC_ACTIVE)
        else $error("vref enable late");
    vref_off_a: assert property ($fell(VREF_HC_REQ) |-> ##[1:20] !VREF_HC_ACTIVE)
        else $error("vref disable late");
    wl_feedback_a: assert property ($rose(DQS) && WL_MODE |->
        ##[1:4] !DQ_OE_N && DQ_OUT == {8{ck_seen}}) else $error("leveling feedback wrong");
endmodule // dram_training_timing_asserts
bind dram_training_timing dram_training_timing_asserts u_chk (.CLK_SYS, .RST_N, .CK, .CKE,
    .CS, .CA, .DQS, .CBT_MODE, .WL_MODE, .VREF_HC_REQ, .DQ_OUT, .DQ_OE_N, .TERM_ON,
    .VREF_HC_ACTIVE);
`default_nettype wire

// [sim/dram_training_timing_tb.sv]
// Testbench for the device-side training logic.
`timescale 1ns/100ps
`default_nettype none
module dram_training_timing_tb;
    logic       CLK_SYS = 1'b0;
    logic       RST_N = 1'b0;
    logic       req = 1'b0;
    wire logic  ck, cke, cs, dqs, cbt, wl, oe_n, term, act, busy;
    wire logic [5:0] ca;
    wire logic [7:0] dq;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    initial forever #2.5 CLK_SYS = ~CLK_SYS;
    dram_ctl_model ctl (.clk(CLK_SYS), .ck, .cke, .cs, .ca, .dqs, .cbt, .wl);
    dram_training_timing dut (.CLK_SYS, .RST_N, .CK(ck), .CKE(cke), .CS(cs), .CA(ca),
        .DQS(dqs), .CBT_MODE(cbt), .WL_MODE(wl), .VREF_HC_REQ(req), .DQ_OUT(dq),
        .DQ_OE_N(oe_n), .TERM_ON(term), .VREF_HC_ACTIVE(act), .VREF_HC_BUSY(busy));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge CLK_SYS) if (++cycles == 30000)
    begin
        failures++;
        close_out;
    end
    task automatic test_cbt;
        ctl.cbt_enter;
        check(term, 8'h01);
        ctl.cbt_cmd(6'h2A, 12);
        check(dq, 8'h2A);
        check(oe_n, 8'h00);
        ctl.cbt_cmd(6'h15, 0);
        ctl.cbt_cmd(6'h33, 12);
        check(dq, 8'h33);
        ctl.cbt_exit;
        check(term, 8'h00);
        ctl.tick(2);
        check(oe_n, 8'h01);
        $display("test cbt done");
    endtask
    task automatic test_wl;
        ctl.wl_edge(1'b1);
        check(dq, 8'hFF);
        ctl.wl_edge(1'b0);
        check(dq, 8'h00);
        $display("test wl done");
    endtask
    task automatic test_vref;
        req <= 1'b1;
        ctl.tick(20);
        check(busy, 8'h01);
        ctl.tick(21);
        check(act, 8'h01);
        check(busy, 8'h00);
        req <= 1'b0;
        ctl.tick(21);
        check(act, 8'h00);
        $display("test vref done");
    endtask
    initial
    begin
        ctl.tick(12);
        check({oe_n, term, act}, 8'h04);
        RST_N <= 1'b1;
        ctl.tick(2);
        test_cbt;
        test_wl;
        test_vref;
        close_out;
    end
endmodule // dram_training_timing_tb
`default_nettype wire
